// ==== rtl/ces_exception_seq.sv ====
// Exception, reset and stack sequencer with flag and branch logic of an 8-bit core.
//
// The strobed register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
module ces_exception_seq (
  input logic clock,
  input logic rst_n,
  input logic cmd_valid,
  input ces_pkg::ces_cmd_t cmd,
  input logic irq_line,
  input logic [7:0] mem_rdata,
  input ces_pkg::ces_reg_req_t reg_req,
  output logic busy_q,
  output ces_pkg::ces_mem_req_t mem_req_q,
  output logic [7:0] reg_rdata_q,
  output logic [ces_pkg::PC_W-1:0] pc_q,
  output logic [7:0] acc_q,
  output logic [7:0] idx_q,
  output ces_pkg::ces_cc_t cc_q,
  output logic [7:0] stack_ptr_q,
  output logic [7:0] port_ddr_q
);
  import ces_pkg::*;

  logic [1:0] rst_sync_q;
  logic rst_i_n;
  ces_state_t state_q, state_d;
  logic [2:0] cnt_q, cnt_d;
  logic [7:0] vec_q, vec_d;
  logic [PC_W-1:0] pc_d;
  logic [7:0] acc_d, idx_d, sp_d, tpre_q, tcnt_q, tcnt_d, ddr_d, reg_rdata_d;
  ces_cc_t cc_d;
  ces_mem_req_t mem_d;
  logic tmr_req_q, tmr_req_d, tmr_mask_q, tmr_mask_d, ext_pend_q, ext_pend_d, irq_prev_q, ext_clr;
  logic cond_hit;
  logic [8:0] rmw_res;

  // The reset is applied at once but released only after two clean edges.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      rst_sync_q <= 2'b00;
    else
      rst_sync_q <= {rst_sync_q[0], 1'b1};
  end
  assign rst_i_n = rst_sync_q[1];

  wire [HI_W-1:0] hi_zero = '0;
  wire [7:0] opnd = cmd.alt ? idx_q : acc_q;
  wire [8:0] diff = {1'b0, opnd} - {1'b0, cmd.data};
  wire [8:0] sum = {1'b0, acc_q} + {1'b0, cmd.data};
  wire [4:0] nib_sum = {1'b0, acc_q[3:0]} + {1'b0, cmd.data[3:0]};
  wire bit_val = cmd.data[cmd.sel[2:0]];
  wire [7:0] bit_mask = 8'h01 << cmd.sel[2:0];
  wire [7:0] sp_inc = stack_ptr_q + 8'h01;
  wire [PC_W-1:0] push_addr = {hi_zero, stack_ptr_q};
  wire [PC_W-1:0] pull_addr = {hi_zero, sp_inc};
  wire [7:0] pch_byte = {{(8 - HI_W){1'b0}}, pc_q[PC_W-1:8]};
  wire [7:0] cc_byte = {3'h0, cc_q};
  wire [7:0] push_byte = (cnt_q == 3'h0) ? pc_q[7:0] : (cnt_q == 3'h1) ? pch_byte :
                         (cnt_q == 3'h2) ? idx_q : (cnt_q == 3'h3) ? acc_q : cc_byte;
  wire tmr_tick = (tpre_q == 8'h00);
  wire [7:0] tcnt_next = tcnt_q - 8'h01;
  wire tmr_evt = tmr_tick && (tcnt_next == 8'h00);
  wire tmr_want = tmr_req_q && !tmr_mask_q;
  wire ext_fall = irq_prev_q && !irq_line;
  wire wr_tctl = reg_req.we && (reg_req.addr == REG_TCTL);
  wire wr_ddr = reg_req.we && (reg_req.addr == REG_DDR);
  wire [7:0] reg_mux = (reg_req.addr == REG_TCTL) ? {tmr_req_q, tmr_mask_q, 6'h00} :
                       (reg_req.addr == REG_DDR) ? port_ddr_q :
                       (reg_req.addr == REG_TCNT) ? tcnt_q :
                       (reg_req.addr == REG_TPRE) ? tpre_q :
                       (reg_req.addr == REG_FLAGS) ? cc_byte :
                       (reg_req.addr == REG_SP) ? stack_ptr_q : 8'h00;

  // Returns the carry and the result of a read-modify-write on one register.
  function automatic logic [8:0] rmw_f(input ces_rmw_t k, input logic [7:0] v, input logic c);
    unique case (k)
      RMW_CLR: rmw_f = {1'b0, 8'h00};
      RMW_COM: rmw_f = {1'b1, ~v};
      RMW_NEG: rmw_f = {v != 8'h00, 8'h00 - v};
      RMW_INC: rmw_f = {c, v + 8'h01};
      RMW_DEC: rmw_f = {c, v - 8'h01};
      RMW_SHIFT_LEFT: rmw_f = {v, 1'b0};
      RMW_LSR: rmw_f = {v[0], 1'b0, v[7:1]};
      RMW_ASR: rmw_f = {v[0], v[7], v[7:1]};
      RMW_ROL: rmw_f = {v, c};
      RMW_ROR: rmw_f = {v[0], c, v[7:1]};
      default: rmw_f = {c, v};
    endcase
  endfunction

  assign rmw_res = rmw_f(ces_rmw_t'(cmd.sel), opnd, cc_q.c);

  always_comb
  begin
    unique case (ces_cond_t'(cmd.sel))
      BRANCH_IRQ_LINE_HIGH: cond_hit = irq_line;
      BRANCH_IRQ_LINE_LOW: cond_hit = !irq_line;
      BRANCH_MASK_SET: cond_hit = cc_q.i;
      BRANCH_MASK_CLEAR: cond_hit = !cc_q.i;
      BRANCH_HALF_CARRY_SET: cond_hit = cc_q.h;
      BRANCH_HALF_CARRY_CLEAR: cond_hit = !cc_q.h;
      BRANCH_UNSIGNED_GE: cond_hit = !cc_q.c;
      BRANCH_UNSIGNED_LT: cond_hit = cc_q.c;
      BRANCH_ALWAYS: cond_hit = 1'b1;
      BRANCH_EQ: cond_hit = cc_q.z;
      BRANCH_NE: cond_hit = !cc_q.z;
      BRANCH_MI: cond_hit = cc_q.n;
      BRANCH_PL: cond_hit = !cc_q.n;
      default: cond_hit = 1'b0;
    endcase
  end

  // There is deliberately no overflow flag; only half carry, interrupt mask, sign, zero and carry exist.
  always_comb
  begin
    state_d = state_q;
    cnt_d = cnt_q;
    vec_d = vec_q;
    pc_d = pc_q;
    acc_d = acc_q;
    idx_d = idx_q;
    cc_d = cc_q;
    sp_d = stack_ptr_q;
    mem_d = '0;
    ext_clr = 1'b0;
    unique case (state_q)
      S_IDLE:
      begin
        if (cmd_valid)
        begin
          pc_d = cmd.next_pc;
          unique case (cmd.op)
            OP_PROGRAM_TRAP:
            begin
              state_d = S_PUSH;
              cnt_d = 3'h0;
              vec_d = VEC_TRAP;
            end
            OP_RETURN_FROM_TRAP:
            begin
              state_d = S_PULL;
              cnt_d = 3'h0;
            end
            OP_STACK_REINIT: sp_d = SP_RESET;
            OP_BRANCH: pc_d = cond_hit ? cmd.target : cmd.next_pc;
            OP_BIT_SET, OP_BIT_CLEAR:
            begin
              mem_d.addr = {hi_zero, cmd.target[7:0]};
              mem_d.wdata = (cmd.op == OP_BIT_SET) ? (cmd.data | bit_mask) : (cmd.data & ~bit_mask);
              mem_d.we = 1'b1;
            end
            OP_BIT_TEST:
            begin
              cc_d.c = bit_val;
              pc_d = (bit_val == cmd.alt) ? cmd.target : cmd.next_pc;
            end
            OP_CMP, OP_SUB:
            begin
              cc_d.c = diff[8];
              cc_d.n = diff[7];
              cc_d.z = (diff[7:0] == 8'h00);
              if (cmd.op == OP_SUB)
                acc_d = diff[7:0];
            end
            OP_ADD:
            begin
              acc_d = sum[7:0];
              cc_d.h = nib_sum[4];
              cc_d.c = sum[8];
              cc_d.n = sum[7];
              cc_d.z = (sum[7:0] == 8'h00);
            end
            OP_LOAD, OP_RMW:
            begin
              if (cmd.op == OP_RMW)
                cc_d.c = rmw_res[8];
              cc_d.n = (cmd.op == OP_RMW) ? rmw_res[7] : cmd.data[7];
              cc_d.z = (cmd.op == OP_RMW) ? (rmw_res[7:0] == 8'h00) : (cmd.data == 8'h00);
              if (cmd.alt)
                idx_d = (cmd.op == OP_RMW) ? rmw_res[7:0] : cmd.data;
              else
                acc_d = (cmd.op == OP_RMW) ? rmw_res[7:0] : cmd.data;
            end
            OP_COPY_ACC_TO_INDEX: idx_d = acc_q;
            OP_COPY_INDEX_TO_ACC: acc_d = idx_q;
            OP_MASK_SET: cc_d.i = 1'b1;
            OP_MASK_CLEAR: cc_d.i = 1'b0;
            default: ;
          endcase
        end
        // A hardware request is taken only once the instruction of this cycle is complete.
        if ((state_d == S_IDLE) && !cc_d.i && (ext_pend_q || tmr_want))
        begin
          state_d = S_PUSH;
          cnt_d = 3'h0;
          vec_d = ext_pend_q ? VEC_EXT : VEC_TIMER;
          ext_clr = ext_pend_q;
        end
      end
      S_PUSH:
      begin
        mem_d.addr = push_addr;
        mem_d.wdata = push_byte;
        mem_d.we = 1'b1;
        sp_d = stack_ptr_q - 8'h01;
        cnt_d = cnt_q + 3'h1;
        if (cnt_q == PUSH_LAST)
        begin
          state_d = S_VEC_HI;
          cc_d.i = 1'b1;
        end
      end
      S_VEC_HI:
      begin
        mem_d.addr = {VEC_PAGE, vec_q};
        mem_d.re = 1'b1;
        state_d = S_VEC_LO;
      end
      S_VEC_LO:
      begin
        mem_d.addr = {VEC_PAGE, vec_q | VEC_LOW_SEL};
        mem_d.re = 1'b1;
        state_d = S_VEC_CAP;
      end
      S_VEC_CAP:
      begin
        pc_d[PC_W-1:8] = mem_rdata[HI_W-1:0];
        state_d = S_VEC_END;
      end
      S_VEC_END:
      begin
        pc_d[7:0] = mem_rdata;
        state_d = S_IDLE;
      end
      S_PULL:
      begin
        if (cnt_q < PULL_ISSUES)
        begin
          sp_d = sp_inc;
          mem_d.addr = pull_addr;
          mem_d.re = 1'b1;
        end
        // Read data trail their strobe by two cycles, so capture lags the issue count.
        unique case (cnt_q)
          3'h2: cc_d = ces_cc_t'(mem_rdata[4:0]);
          3'h3: acc_d = mem_rdata;
          3'h4: idx_d = mem_rdata;
          3'h5: pc_d[PC_W-1:8] = mem_rdata[HI_W-1:0];
          3'h6: pc_d[7:0] = mem_rdata;
          default: ;
        endcase
        cnt_d = cnt_q + 3'h1;
        if (cnt_q == PULL_LAST)
          state_d = S_IDLE;
      end
    endcase
  end

  assign ext_pend_d = ext_fall || (ext_pend_q && !ext_clr);
  assign tmr_req_d = tmr_evt || (tmr_req_q && !(wr_tctl && !reg_req.wdata[TCTL_REQ]));
  assign tmr_mask_d = wr_tctl ? reg_req.wdata[TCTL_MASK] : tmr_mask_q;
  assign tcnt_d = tmr_tick ? tcnt_next : tcnt_q;
  assign ddr_d = wr_ddr ? reg_req.wdata : port_ddr_q;
  assign reg_rdata_d = reg_req.re ? reg_mux : 8'h00;

  // After reset the core fetches the reset vector before it accepts any command.
  always_ff @(posedge clock or negedge rst_i_n)
  begin
    if (!rst_i_n)
    begin
      state_q <= S_VEC_HI;
      vec_q <= VEC_RESET;
      cnt_q <= 3'h0;
      pc_q <= '0;
      acc_q <= 8'h00;
      idx_q <= 8'h00;
      cc_q <= CC_RESET;
      stack_ptr_q <= SP_RESET;
      tmr_mask_q <= 1'b1;
      tpre_q <= TMR_PRESET;
      tcnt_q <= TMR_PRESET;
      port_ddr_q <= DDR_RESET;
      tmr_req_q <= 1'b0;
      ext_pend_q <= 1'b0;
      irq_prev_q <= 1'b1;
      busy_q <= 1'b1;
      mem_req_q <= '0;
      reg_rdata_q <= 8'h00;
    end
    else
    begin
      state_q <= state_d;
      vec_q <= vec_d;
      cnt_q <= cnt_d;
      pc_q <= pc_d;
      acc_q <= acc_d;
      idx_q <= idx_d;
      cc_q <= cc_d;
      stack_ptr_q <= sp_d;
      tmr_mask_q <= tmr_mask_d;
      tpre_q <= tpre_q - 8'h01;
      tcnt_q <= tcnt_d;
      port_ddr_q <= ddr_d;
      tmr_req_q <= tmr_req_d;
      ext_pend_q <= ext_pend_d;
      irq_prev_q <= irq_line;
      busy_q <= (state_d != S_IDLE);
      mem_req_q <= mem_d;
      reg_rdata_q <= reg_rdata_d;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_i_n);

  wire take_cmd = (state_q == S_IDLE) && cmd_valid;

  sequence s_state_pushed;
    mem_req_q.we && (mem_req_q.wdata == pc_q[7:0]) ##1 mem_req_q.wdata == pch_byte
      ##1 mem_req_q.wdata == idx_q ##1 mem_req_q.wdata == acc_q;
  endsequence

  sequence s_vector_reads;
    mem_req_q.re && (mem_req_q.addr == {VEC_PAGE, vec_q})
      ##1 mem_req_q.re && (mem_req_q.addr == {VEC_PAGE, vec_q | VEC_LOW_SEL});
  endsequence

  a_trap_start: assert property (take_cmd && (cmd.op == OP_PROGRAM_TRAP) |=> state_q == S_PUSH)
    else $error("program trap not taken");
  a_push_order: assert property ((state_q == S_PUSH) && (cnt_q == 3'h0) |=> s_state_pushed)
    else $error("push order wrong");
  a_push_addr: assert property ((state_q == S_PUSH) |=> (mem_req_q.addr == {hi_zero, $past(stack_ptr_q)})
    && (stack_ptr_q == $past(stack_ptr_q) - 8'h01))
    else $error("push address or pointer wrong");
  a_mask_vector: assert property ((state_q == S_PUSH) && (cnt_q == PUSH_LAST) |=> cc_q.i ##1 s_vector_reads)
    else $error("mask or vector fetch wrong");
  a_pull_step: assert property ((state_q == S_PULL) && (cnt_q < PULL_ISSUES) |=> mem_req_q.re
    && (mem_req_q.addr == {hi_zero, stack_ptr_q}) && (stack_ptr_q == $past(stack_ptr_q) + 8'h01))
    else $error("pull step wrong");
  a_reinit_sp: assert property (take_cmd && (cmd.op == OP_STACK_REINIT) |=> stack_ptr_q == SP_RESET)
    else $error("stack reinit wrong");
  a_bit_carry: assert property (take_cmd && (cmd.op == OP_BIT_TEST) |=> cc_q.c == $past(bit_val))
    else $error("bit test carry wrong");
  a_cmp_carry: assert property (take_cmd && (cmd.op == OP_CMP) |=> cc_q.c == ($past(opnd) < $past(cmd.data)))
    else $error("compare carry wrong");
  a_ext_clear: assert property (ext_clr && !ext_fall |=> !ext_pend_q ##1 state_q == S_PUSH)
    else $error("external request not cleared");
  a_mask_branch: assert property (take_cmd && (cmd.op == OP_BRANCH) && (cmd.sel == 4'h2)
    |=> pc_q == ($past(cc_q.i) ? $past(cmd.target) : $past(cmd.next_pc)))
    else $error("mask branch wrong");
endmodule // ces_exception_seq

// ==== rtl/ces_pkg.sv ====
// Constants and types shared by the exception sequencer.
package ces_pkg;
  localparam int PC_W = 13;
  localparam int HI_W = PC_W - 8;
  localparam logic [HI_W-1:0] VEC_PAGE = '1;
  localparam logic [7:0] VEC_TIMER = 8'hF8;
  localparam logic [7:0] VEC_EXT = 8'hFA;
  localparam logic [7:0] VEC_TRAP = 8'hFC;
  localparam logic [7:0] VEC_RESET = 8'hFE;
  localparam logic [7:0] VEC_LOW_SEL = 8'h01;
  localparam logic [7:0] SP_RESET = 8'h7F;
  localparam logic [7:0] TMR_PRESET = 8'hFF;
  localparam logic [7:0] DDR_RESET = 8'h00;
  localparam logic [2:0] PUSH_LAST = 3'h4;
  localparam logic [2:0] PULL_ISSUES = 3'h5;
  localparam logic [2:0] PULL_LAST = 3'h6;
  localparam logic [2:0] REG_TCTL = 3'h0;
  localparam logic [2:0] REG_DDR = 3'h1;
  localparam logic [2:0] REG_TCNT = 3'h2;
  localparam logic [2:0] REG_TPRE = 3'h3;
  localparam logic [2:0] REG_FLAGS = 3'h4;
  localparam logic [2:0] REG_SP = 3'h5;
  localparam int TCTL_REQ = 7;
  localparam int TCTL_MASK = 6;

  typedef enum logic [4:0] {
    OP_NOP, OP_PROGRAM_TRAP, OP_RETURN_FROM_TRAP, OP_STACK_REINIT, OP_BRANCH,
    OP_BIT_SET, OP_BIT_CLEAR, OP_BIT_TEST, OP_CMP, OP_SUB, OP_ADD, OP_LOAD, OP_RMW,
    OP_COPY_ACC_TO_INDEX, OP_COPY_INDEX_TO_ACC, OP_MASK_SET, OP_MASK_CLEAR
  } ces_op_t;

  // Carry clear and carry set share the unsigned ge and lt codes.
  typedef enum logic [3:0] {
    BRANCH_IRQ_LINE_HIGH, BRANCH_IRQ_LINE_LOW, BRANCH_MASK_SET, BRANCH_MASK_CLEAR,
    BRANCH_HALF_CARRY_SET, BRANCH_HALF_CARRY_CLEAR, BRANCH_UNSIGNED_GE, BRANCH_UNSIGNED_LT,
    BRANCH_ALWAYS, BRANCH_NEVER, BRANCH_EQ, BRANCH_NE, BRANCH_MI, BRANCH_PL
  } ces_cond_t;

  // Logical and arithmetic left shift are one operation.
  typedef enum logic [3:0] {
    RMW_CLR, RMW_COM, RMW_NEG, RMW_INC, RMW_DEC, RMW_SHIFT_LEFT, RMW_LSR, RMW_ASR,
    RMW_ROL, RMW_ROR, RMW_TST
  } ces_rmw_t;

  typedef enum {S_IDLE, S_PUSH, S_VEC_HI, S_VEC_LO, S_VEC_CAP, S_VEC_END, S_PULL} ces_state_t;

  typedef struct packed {
    logic h;
    logic i;
    logic n;
    logic z;
    logic c;
  } ces_cc_t;

  localparam ces_cc_t CC_RESET = '{h: 1'b0, i: 1'b1, n: 1'b0, z: 1'b0, c: 1'b0};

  typedef struct packed {
    ces_op_t op;
    logic [3:0] sel;
    logic alt;
    logic [7:0] data;
    logic [PC_W-1:0] next_pc;
    logic [PC_W-1:0] target;
  } ces_cmd_t;

  typedef struct packed {
    logic [PC_W-1:0] addr;
    logic [7:0] wdata;
    logic we;
    logic re;
  } ces_mem_req_t;

  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic we;
    logic re;
  } ces_reg_req_t;
endpackage

// ==== sim/ces_mem_model.sv ====
// Behavioural program memory and stack RAM on the core bus.
`timescale 1ns/1ps
module ces_mem_model
  import ces_pkg::*;
#(
  parameter logic [PC_W-1:0] RST_V = 13'h0123,
  parameter logic [PC_W-1:0] TRAP_V = 13'h0456,
  parameter logic [PC_W-1:0] EXT_V = 13'h0789,
  parameter logic [PC_W-1:0] TMR_V = 13'h0ABC
)
(
  input wire logic clock,
  input ces_pkg::ces_mem_req_t req,
  output logic [7:0] rdata
);
  logic [7:0] mem [0:(1<<PC_W)-1];
  initial
  begin
    rdata = 8'hA5;
    foreach (mem[k])
      mem[k] = 8'(k * 7);
    {mem[{VEC_PAGE, VEC_RESET}], mem[{VEC_PAGE, VEC_RESET | VEC_LOW_SEL}]} = {3'h0, RST_V};
    {mem[{VEC_PAGE, VEC_TRAP}], mem[{VEC_PAGE, VEC_TRAP | VEC_LOW_SEL}]} = {3'h0, TRAP_V};
    {mem[{VEC_PAGE, VEC_EXT}], mem[{VEC_PAGE, VEC_EXT | VEC_LOW_SEL}]} = {3'h0, EXT_V};
    {mem[{VEC_PAGE, VEC_TIMER}], mem[{VEC_PAGE, VEC_TIMER | VEC_LOW_SEL}]} = {3'h0, TMR_V};
  end
  // Outside a read answer the data toggles so a late sample never looks valid.
  always @(posedge clock)
  begin
    if (req.we)
      mem[req.addr] <= req.wdata;
    rdata <= req.re ? mem[req.addr] : ~rdata;
  end
endmodule // ces_mem_model

// ==== sim/ces_exception_seq_test.sv ====
// Self-checking testbench for the exception sequencer.
`timescale 1ns/1ps
module ces_exception_seq_test;
  import ces_pkg::*;
  typedef struct packed {logic we; logic [PC_W-1:0] addr; logic [7:0] data; logic [7:0] mask;} ces_exp_t;
  localparam logic [PC_W-1:0] RST_V = 13'h0123;
  localparam logic [PC_W-1:0] TRAP_V = 13'h0456;
  localparam logic [PC_W-1:0] EXT_V = 13'h0789;
  localparam logic [PC_W-1:0] TMR_V = 13'h0ABC;
  logic clock, rst_n, cmd_valid, irq_line, busy_q, rd_pend;
  ces_cmd_t cmd;
  ces_reg_req_t reg_req;
  ces_mem_req_t mem_req_q;
  ces_cc_t cc_q;
  logic [PC_W-1:0] pc_q, np, tg;
  logic [7:0] mem_rdata, reg_rdata_q, acc_q, idx_q, stack_ptr_q, port_ddr_q, a, x, m, d, v;
  int err_count, n_checks, n_wait;
  ces_exp_t e;
  ces_exp_t exp_mem[$];
  logic [7:0] exp_reg[$];

  ces_exception_seq dut_u (.clock, .rst_n, .cmd_valid, .cmd, .irq_line, .mem_rdata, .reg_req, .busy_q,
    .mem_req_q, .reg_rdata_q, .pc_q, .acc_q, .idx_q, .cc_q, .stack_ptr_q, .port_ddr_q);
  ces_mem_model #(.RST_V(RST_V), .TRAP_V(TRAP_V), .EXT_V(EXT_V), .TMR_V(TMR_V)) mem_u (.clock(clock),
    .req(mem_req_q), .rdata(mem_rdata));

  task automatic chk(logic [15:0] got, logic [15:0] exp, string s);
    n_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("[FAIL] %0t %s got %h want %h", $time, s, got, exp);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic endt(string s);
    $display("test %s done", s);
  endtask
  task automatic ex(logic w, logic [PC_W-1:0] ad, logic [7:0] dt, logic [7:0] mk);
    exp_mem.push_back('{w, ad, dt, mk});
  endtask
  task automatic idle();
    int n;
    n = 0;
    while (busy_q !== 1'b0 && n < 50)
    begin
      @(posedge clock);
      #1;
      n++;
    end
    chk(busy_q, 16'h0, "busy stuck");
  endtask
  task automatic run(ces_op_t op, logic [3:0] s, logic alt, logic [7:0] dt, logic [PC_W-1:0] p,
    logic [PC_W-1:0] t);
    idle();
    @(posedge clock);
    cmd_valid <= 1'b1;
    cmd <= '{op: op, sel: s, alt: alt, data: dt, next_pc: p, target: t};
    @(posedge clock);
    cmd_valid <= 1'b0;
    @(posedge clock);
    #1;
  endtask
  task automatic reg_op(logic w, logic [2:0] ad, logic [7:0] dt);
    if (!w)
      exp_reg.push_back(dt);
    @(posedge clock);
    reg_req <= '{addr: ad, wdata: dt, we: w, re: !w};
    @(posedge clock);
    reg_req <= '0;
  endtask
  task automatic pushes(logic [PC_W-1:0] p, logic [7:0] xv, logic [7:0] av, logic [7:0] c, logic [7:0] vec);
    ex(1'b1, 13'h007F, p[7:0], 8'hFF);
    ex(1'b1, 13'h007E, {3'h0, p[12:8]}, 8'h1F);
    ex(1'b1, 13'h007D, xv, 8'hFF);
    ex(1'b1, 13'h007C, av, 8'hFF);
    ex(1'b1, 13'h007B, c, 8'hE8);
    ex(1'b0, {VEC_PAGE, vec}, 8'h00, 8'h00);
    ex(1'b0, {VEC_PAGE, vec | VEC_LOW_SEL}, 8'h00, 8'h00);
  endtask
  task automatic pulls();
    for (int k = 0; k < 5; k++)
      ex(1'b0, 13'h007B + 13'(k), 8'h00, 8'h00);
  endtask
  function automatic logic tk(int k, logic l, logic i, logic h, logic c);
    logic [7:0] t;
    t = {c, ~c, ~h, h, ~i, i, ~l, l};
    return t[k];
  endfunction
  task automatic branches(logic l, logic i, logic h, logic c);
    for (int k = 0; k < 8; k++)
    begin
      np = $urandom;
      tg = $urandom;
      run(OP_BRANCH, 4'(k), 1'b0, 8'h00, np, tg);
      chk(pc_q, tk(k, l, i, h, c) ? tg : np, "branch");
    end
  endtask

  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  initial
  begin
    // The timer needs about 65000 cycles from reset to reach zero.
    repeat (90000) @(posedge clock);
    err_count++;
    wrap_up();
  end
  // Results are paired with the oldest outstanding note as they appear.
  always @(posedge clock)
  begin
    rd_pend <= reg_req.re;
    if (rd_pend === 1'b1)
      chk(reg_rdata_q, exp_reg.size() > 0 ? exp_reg.pop_front() : 8'hXX, "reg read");
    if (mem_req_q.we === 1'b1 || mem_req_q.re === 1'b1)
    begin
      e = exp_mem.size() > 0 ? exp_mem.pop_front() : 'x;
      chk({mem_req_q.we, mem_req_q.addr}, {e.we, e.addr}, "mem addr");
      chk(mem_req_q.wdata & e.mask, e.data & e.mask, "mem data");
    end
  end

  initial
  begin
    rst_n = 1'b0;
    cmd_valid = 1'b0;
    cmd = '0;
    irq_line = 1'b1;
    reg_req = '0;
    rd_pend = 1'b0;
    err_count = 0;
    n_checks = 0;
    void'($urandom(69));
    ex(1'b0, {VEC_PAGE, VEC_RESET}, 8'h00, 8'h00);
    ex(1'b0, {VEC_PAGE, VEC_RESET | VEC_LOW_SEL}, 8'h00, 8'h00);
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    idle();
    chk(pc_q, RST_V, "reset pc");
    chk(cc_q, 16'h08, "reset flags");
    chk(stack_ptr_q, 16'h7F, "reset sp");
    chk(port_ddr_q, 16'h00, "reset ddr");
    reg_op(1'b0, REG_TCTL, 8'h40);
    reg_op(1'b0, REG_TCNT, 8'hFF);
    endt("reset");
    a = $urandom;
    x = $urandom;
    np = $urandom;
    run(OP_LOAD, 4'h0, 1'b0, a, 13'h0000, 13'h0000);
    run(OP_LOAD, 4'h0, 1'b1, x, 13'h0000, 13'h0000);
    pushes(np, x, a, 8'h08, VEC_TRAP);
    run(OP_PROGRAM_TRAP, 4'h0, 1'b0, 8'h00, np, 13'h0000);
    idle();
    chk(pc_q, TRAP_V, "trap pc");
    chk(stack_ptr_q, 16'h7A, "trap sp");
    run(OP_LOAD, 4'h0, 1'b0, ~a, 13'h0000, 13'h0000);
    run(OP_LOAD, 4'h0, 1'b1, ~x, 13'h0000, 13'h0000);
    pulls();
    run(OP_RETURN_FROM_TRAP, 4'h0, 1'b0, 8'h00, 13'h0000, 13'h0000);
    idle();
    chk(pc_q, np, "ret pc");
    chk({acc_q, idx_q}, {a, x}, "ret regs");
    chk(stack_ptr_q, 16'h7F, "ret sp");
    pushes(np, x, a, 8'h08, VEC_TRAP);
    run(OP_PROGRAM_TRAP, 4'h0, 1'b0, 8'h00, np, 13'h0000);
    run(OP_STACK_REINIT, 4'h0, 1'b0, 8'h00, 13'h0000, 13'h0000);
    chk(stack_ptr_q, 16'h7F, "reinit sp");
    endt("trap");
    for (int k = 0; k < 8; k++)
    begin
      a = $urandom;
      m = k == 0 ? a : k == 1 ? 8'(a + 8'h01) : 8'($urandom);
      run(OP_LOAD, 4'h0, 1'b0, a, 13'h0000, 13'h0000);
      run(k[0] ? OP_SUB : OP_CMP, 4'h0, 1'b0, m, 13'h0000, 13'h0000);
      chk(cc_q.c, a < m, "carry");
      chk(acc_q, k[0] ? 8'(a - m) : a, "cmp acc");
    end
    endt("compare");
    run(OP_LOAD, 4'h0, 1'b0, 8'h08, 13'h0000, 13'h0000);
    run(OP_ADD, 4'h0, 1'b0, 8'h08, 13'h0000, 13'h0000);
    branches(1'b1, 1'b1, 1'b1, 1'b0);
    @(posedge clock);
    irq_line <= 1'b0;
    branches(1'b0, 1'b1, 1'b1, 1'b0);
    np = $urandom;
    pushes(np, x, 8'h10, 8'h00, VEC_EXT);
    run(OP_MASK_CLEAR, 4'h0, 1'b0, 8'h00, np, 13'h0000);
    idle();
    chk(pc_q, EXT_V, "ext pc");
    chk(cc_q.i, 16'h1, "ext mask");
    pulls();
    run(OP_RETURN_FROM_TRAP, 4'h0, 1'b0, 8'h00, 13'h0000, 13'h0000);
    // Look past the first idle cycle, where a request left pending would start a new push.
    repeat (8) @(posedge clock);
    #1;
    chk({busy_q, pc_q}, {1'b0, np}, "ext once");
    @(posedge clock);
    irq_line <= 1'b1;
    run(OP_LOAD, 4'h0, 1'b0, 8'h10, 13'h0000, 13'h0000);
    run(OP_ADD, 4'h0, 1'b0, 8'hF0, 13'h0000, 13'h0000);
    branches(1'b1, 1'b0, 1'b0, 1'b1);
    endt("branch");
    for (int k = 0; k < 8; k++)
    begin
      d = $urandom;
      np = $urandom;
      tg = $urandom;
      run(OP_BIT_TEST, 4'(k), k[0], d, np, tg);
      chk(cc_q.c, d[k], "bit carry");
      chk(pc_q, d[k] == k[0] ? tg : np, "bit branch");
      m = 8'h01 << k;
      ex(1'b1, {5'h00, tg[7:0]}, k[0] ? d & ~m : d | m, 8'hFF);
      run(k[0] ? OP_BIT_CLEAR : OP_BIT_SET, 4'(k), 1'b0, d, np, tg);
    end
    endt("bits");
    for (int k = 0; k < 8; k++)
    begin
      v = $urandom;
      run(OP_LOAD, 4'h0, k[2], v, 13'h0000, 13'h0000);
      run(OP_RMW, 4'(k[1:0]), k[2], 8'h00, 13'h0000, 13'h0000);
      d = k[1:0] == 0 ? 8'h00 : k[1:0] == 1 ? ~v : k[1:0] == 2 ? 8'(-v) : 8'(v + 8'h01);
      chk(k[2] ? idx_q : acc_q, d, "rmw");
    end
    endt("rmw");
    d = $urandom;
    reg_op(1'b1, REG_DDR, d);
    reg_op(1'b0, REG_DDR, d);
    chk(port_ddr_q, d, "ddr");
    reg_op(1'b1, REG_SP, 8'h00);
    reg_op(1'b0, REG_SP, 8'h7F);
    reg_op(1'b0, 3'h7, 8'h00);
    reg_op(1'b1, REG_TCTL, 8'h00);
    reg_op(1'b0, REG_TCTL, 8'h00);
    repeat (3) @(posedge clock);
    chk(exp_mem.size() + exp_reg.size(), 16'h0, "left over");
    endt("registers");
    a = $urandom;
    x = $urandom;
    np = $urandom;
    run(OP_LOAD, 4'h0, 1'b1, x, np, 13'h0000);
    run(OP_LOAD, 4'h0, 1'b0, a, np, 13'h0000);
    pushes(np, x, a, 8'h00, VEC_TIMER);
    n_wait = 0;
    while (busy_q !== 1'b1 && n_wait < 70000)
    begin
      @(posedge clock);
      #1;
      n_wait++;
    end
    idle();
    chk(pc_q, TMR_V, "timer pc");
    reg_op(1'b0, REG_TCTL, 8'h80);
    reg_op(1'b1, REG_TCTL, 8'h40);
    reg_op(1'b0, REG_TCTL, 8'h40);
    repeat (3) @(posedge clock);
    chk(exp_mem.size() + exp_reg.size(), 16'h0, "timer left over");
    endt("timer");
    wrap_up();
  end
endmodule // ces_exception_seq_test
